// >>> src/option_byte_config_decoder.sv
// Behaviour
// R1: programmer keeps first byte top bit one
// R2: bit 6 picks 16 or 20 pins
// R3: clock field decoded only with RC off
// R4: programmer leaves clock field default with RC
// R5: sector 0 size field gives 0.5k to 4k
// R6: read-out protect blocks extraction and flash writes
// R7: protected option erase erases memory first
// R8: write protect refuses flash and itself forever
// R9: second byte bit 7 picks x4 or x8
// R10: bit 6 one bypasses the PLL
// R11: bit 5 one bypasses the fast PLL
// R12: bit 4 zero turns RC oscillator on
// R13: detector field 11 off, else threshold
// R14: watchdog type zero means always enabled
// R15: halt resets when watchdog active and bit set
// R16: programmer uses only valid clock combinations
// R17: option bytes reachable only in programming mode
// R18: hardware watchdog ignores software activate bit
// R19: decoded settings latched at reset, then held; flash write allow also drops outside reset when the write protect bit is set
`timescale 1ns/1ps
`default_nettype none

module option_byte_config_decoder
	import option_cfg_pkg::*;
(
	input wire logic clk_i, // 50 MHz clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic por_i, // power-on clear of the byte store
	input wire logic prog_mode_pin_i, // programming mode pin
	input wire logic halt_entry_i, // pulse: core enters halt
	input wire logic mem_erase_done_i, // pulse: memory erase finished
	input wire logic [7:0] adr_i, // wishbone byte address
	input wire logic [31:0] dat_i, // wishbone write data
	output logic [31:0] dat_o, // wishbone read data
	input wire logic we_i, // wishbone write enable
	input wire logic [3:0] sel_i, // wishbone byte select
	input wire logic cyc_i, // wishbone cycle
	input wire logic stb_i, // wishbone strobe
	output logic ack_o, // wishbone acknowledge
	output logic pkg_20pin_o, // 20-pin package
	output logic rc_osc_en_o, // internal RC oscillator on
	output logic sel_resonator_o, // resonator clock
	output logic sel_ext_pb4_o, // external clock on port b bit 4
	output logic sel_ext_pc0_o, // external clock on port c bit 0
	output logic clock_field_reserved_o, // reserved clock code
	output logic [12:0] sector_zero_bytes_o, // sector 0 size
	output logic readout_protect_o, // read-out protection on
	output logic program_write_protect_o, // write protection on
	output logic flash_write_allow_o, // flash may be written
	output logic pll_x8_o, // PLL multiplies by 8
	output logic pll_enable_o, // PLL in use
	output logic fast_pll_enable_o, // 32 MHz PLL in use
	output logic lvd_enable_o, // low-voltage detector on
	output logic lvd_high_o, // highest threshold
	output logic lvd_medium_o, // medium threshold
	output logic lvd_low_o, // lowest threshold
	output logic watchdog_hw_o, // hardware watchdog type
	output logic watchdog_active_o, // watchdog running
	output logic halt_reset_o, // pulse: reset on halt entry
	output logic mem_erase_req_o // level: whole memory erase
);

	logic prog_mode;
	logic req;
	logic wr;
	logic [7:0] nv0_reg, nv0_next;
	logic [7:0] nv1_reg, nv1_next;
	erase_state_t state_reg, state_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic wdg_act_reg, wdg_act_next;
	logic wdg_active_reg, wdg_active_next;
	logic halt_rst_reg, halt_rst_next;
	logic watchdog_halt_reset_reg;
	logic [1:0] clk_field;
	logic [1:0] lvd_field;
	logic rc_on;
	logic [21:0] cfg_reg, cfg_next;

	level_sync u_prog_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(prog_mode_pin_i),
		.sync_o(prog_mode)
	);

	// bus slave: one ack per request, registered read data
	assign req = cyc_i & stb_i & ~ack_reg;
	assign wr = req & we_i & sel_i[0];

	always_comb
	begin
		ack_next = req;
		dat_next = dat_reg;
		if (req)
		begin
			dat_next = 32'h0000_0000;
			unique case (adr_i)
				ADDR_OPT0: if (prog_mode) dat_next[7:0] = nv0_reg; // R17
				ADDR_OPT1: if (prog_mode) dat_next[7:0] = nv1_reg; // R17
				ADDR_STATUS:
				begin
					dat_next[ST_PROG_BIT] = prog_mode;
					dat_next[ST_BUSY_BIT] = (state_reg != ST_IDLE);
					dat_next[ST_WDG_BIT] = wdg_active_reg;
					dat_next[ST_FLASH_BIT] = flash_write_allow_o;
				end
				ADDR_WDG: dat_next[WDG_ACT_BIT] = wdg_act_reg;
				default: dat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// option byte store and erase sequence
	always_comb
	begin
		nv0_next = nv0_reg;
		nv1_next = nv1_reg;
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (wr && prog_mode && adr_i == ADDR_OPT0) // R17
					nv0_next = dat_i[7:0] | (nv0_reg & WRP_MASK); // R8
				if (wr && prog_mode && adr_i == ADDR_OPT1) // R17
					nv1_next = dat_i[7:0];
				if (wr && prog_mode && adr_i == ADDR_CMD &&
					dat_i[CMD_ERASE_BIT])
				begin
					if (nv0_reg[RDP_BIT] && nv0_reg[WRP_BIT])
						state_next = ST_IDLE; // R8
					else if (nv0_reg[RDP_BIT])
						state_next = ST_MEM_ERASE; // R7
					else
						state_next = ST_OPT_ERASE;
				end
			end
			ST_MEM_ERASE:
				if (mem_erase_done_i)
					state_next = ST_OPT_ERASE; // R7
			ST_OPT_ERASE:
			begin
				nv0_next = OPT0_DEFAULT | (nv0_reg & WRP_MASK); // R8
				nv1_next = OPT1_DEFAULT;
				state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			nv0_reg <= OPT0_DEFAULT;
			nv1_reg <= OPT1_DEFAULT;
			state_reg <= ST_IDLE;
		end
		else if (rst_i)
			state_reg <= ST_IDLE;
		else
		begin
			nv0_reg <= nv0_next;
			nv1_reg <= nv1_next;
			state_reg <= state_next;
		end
	end

	assign mem_erase_req_o = (state_reg == ST_MEM_ERASE); // R7

	// decoded settings, captured while reset is held
	assign clk_field = nv0_reg[CLK_HI:CLK_LO];
	assign lvd_field = nv1_reg[LVD_HI:LVD_LO];
	assign rc_on = ~nv1_reg[RCOFF_BIT]; // R12

	always_comb
	begin
		cfg_next = cfg_reg;
		if (rst_i)
		begin
			cfg_next[0] = nv0_reg[PKG_BIT]; // R2
			cfg_next[1] = rc_on; // R12
			cfg_next[2] = ~rc_on && clk_field == CLK_RESONATOR; // R3
			cfg_next[3] = ~rc_on && clk_field == CLK_EXT_PB4; // R3
			cfg_next[4] = ~rc_on && clk_field == CLK_EXT_PC0; // R3
			cfg_next[5] = ~rc_on && clk_field == CLK_RESERVED; // R3
			cfg_next[18:6] =
				SECTOR_BASE_BYTES << nv0_reg[SEC_HI:SEC_LO]; // R5
			cfg_next[19] = nv1_reg[PLLF_BIT]; // R9
			cfg_next[20] = ~nv1_reg[PLLBYP_BIT]; // R10
			cfg_next[21] = ~nv1_reg[FPLLBYP_BIT]; // R11
		end
	end

	logic rdp_reg, wrp_reg, fwa_reg, fwa_next;
	logic lvd_en_reg, lvd_hi_reg, lvd_med_reg, lvd_lo_reg, wdg_hw_reg;

	always_comb
	begin
		fwa_next = ~rdp_reg & ~wrp_reg & ~nv0_reg[WRP_BIT]; // R6 R8
		if (rst_i)
			fwa_next = ~nv0_reg[RDP_BIT] & ~nv0_reg[WRP_BIT]; // R6 R8
	end

	always_ff @(posedge clk_i)
	begin
		cfg_reg <= cfg_next; // R19
		fwa_reg <= fwa_next;
		if (rst_i)
		begin
			rdp_reg <= nv0_reg[RDP_BIT]; // R6
			wrp_reg <= nv0_reg[WRP_BIT]; // R8
			lvd_en_reg <= lvd_field != LVD_OFF; // R13
			lvd_hi_reg <= lvd_field == LVD_HIGH; // R13
			lvd_med_reg <= lvd_field == LVD_MEDIUM; // R13
			lvd_lo_reg <= lvd_field == LVD_LOW; // R13
			wdg_hw_reg <= ~nv1_reg[WDTYPE_BIT]; // R14
			watchdog_halt_reset_reg <= nv1_reg[WDHALT_BIT]; // R15
		end
	end

	assign pkg_20pin_o = cfg_reg[0];
	assign rc_osc_en_o = cfg_reg[1];
	assign sel_resonator_o = cfg_reg[2];
	assign sel_ext_pb4_o = cfg_reg[3];
	assign sel_ext_pc0_o = cfg_reg[4];
	assign clock_field_reserved_o = cfg_reg[5];
	assign sector_zero_bytes_o = cfg_reg[18:6];
	assign pll_x8_o = cfg_reg[19];
	assign pll_enable_o = cfg_reg[20];
	assign fast_pll_enable_o = cfg_reg[21];
	assign readout_protect_o = rdp_reg;
	assign program_write_protect_o = wrp_reg;
	assign flash_write_allow_o = fwa_reg;
	assign lvd_enable_o = lvd_en_reg;
	assign lvd_high_o = lvd_hi_reg;
	assign lvd_medium_o = lvd_med_reg;
	assign lvd_low_o = lvd_lo_reg;
	assign watchdog_hw_o = wdg_hw_reg;

	// watchdog activation and halt reset
	always_comb
	begin
		wdg_act_next = wdg_act_reg;
		if (wr && adr_i == ADDR_WDG && dat_i[WDG_ACT_BIT])
			wdg_act_next = 1'b1;
		wdg_active_next = wdg_hw_reg | wdg_act_reg; // R14 R18
		halt_rst_next = halt_entry_i & wdg_active_reg & watchdog_halt_reset_reg; // R15
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wdg_act_reg <= 1'b0;
			wdg_active_reg <= 1'b0;
			halt_rst_reg <= 1'b0;
		end
		else
		begin
			wdg_act_reg <= wdg_act_next;
			wdg_active_reg <= wdg_active_next;
			halt_rst_reg <= halt_rst_next;
		end
	end

	assign watchdog_active_o = wdg_active_reg;
	assign halt_reset_o = halt_rst_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);

	sequence erase_cmd_s;
		wr && prog_mode && adr_i == ADDR_CMD && dat_i[CMD_ERASE_BIT] &&
			state_reg == ST_IDLE;
	endsequence

	sequence protected_erase_s;
		erase_cmd_s ##0 (nv0_reg[RDP_BIT] && !nv0_reg[WRP_BIT]);
	endsequence

	chk_optwr_gated: assert property ( // R17
		wr && !prog_mode && adr_i == ADDR_OPT0 |=> $stable(nv0_reg))
		else $error("option byte written outside programming mode");
	chk_read_blank: assert property ( // R17
		req && !prog_mode && adr_i == ADDR_OPT1 |=> dat_o == 32'h0)
		else $error("option byte readable outside programming mode");
	chk_wrp_sticky: assert property ( // R8
		nv0_reg[WRP_BIT] |=> nv0_reg[WRP_BIT])
		else $error("write protect bit was cleared");
	chk_flash_block: assert property ( // R6
		(readout_protect_o || program_write_protect_o) |->
			!flash_write_allow_o)
		else $error("flash writable while protected");
	chk_erase_order: assert property ( // R7
		protected_erase_s |=> mem_erase_req_o && nv0_reg[RDP_BIT])
		else $error("option erase did not erase memory first");
	chk_erase_finish: assert property ( // R7
		mem_erase_req_o && mem_erase_done_i |=> ##1
			nv1_reg == OPT1_DEFAULT && !mem_erase_req_o)
		else $error("option bytes not erased after memory erase");
	chk_hw_watchdog: assert property ( // R18
		watchdog_hw_o && !$past(rst_i) |-> watchdog_active_o)
		else $error("hardware watchdog not active");
	chk_halt_reset: assert property ( // R15
		halt_entry_i && watchdog_active_o |=> halt_reset_o == watchdog_halt_reset_reg)
		else $error("halt reset does not follow option bit");
	chk_clock_decode: assert property ( // R3
		rc_osc_en_o |-> !(sel_resonator_o || sel_ext_pb4_o ||
			sel_ext_pc0_o || clock_field_reserved_o))
		else $error("clock source decoded while RC oscillator on");
	chk_sector_size: assert property ( // R5
		$onehot(sector_zero_bytes_o[12:9]) &&
			sector_zero_bytes_o[8:0] == 9'h000)
		else $error("sector 0 size not a legal value");
	chk_cfg_held: assert property ( // R19
		!$past(rst_i) |-> $stable(cfg_reg) && $stable(wdg_hw_reg))
		else $error("latched settings changed outside reset");

endmodule : option_byte_config_decoder

`default_nettype wire

// >>> src/option_cfg_pkg.sv
package option_cfg_pkg;

	// default (shipped) option byte contents
	localparam logic [7:0] OPT0_DEFAULT = 8'hF4;
	localparam logic [7:0] OPT1_DEFAULT = 8'hEF;

	// register byte offsets
	localparam logic [7:0] ADDR_OPT0 = 8'h00;
	localparam logic [7:0] ADDR_OPT1 = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0C;
	localparam logic [7:0] ADDR_WDG = 8'h10;

	// first option byte fields
	localparam int PKG_BIT = 6;
	localparam int CLK_HI = 5;
	localparam int CLK_LO = 4;
	localparam int SEC_HI = 3;
	localparam int SEC_LO = 2;
	localparam int RDP_BIT = 1;
	localparam int WRP_BIT = 0;
	localparam logic [7:0] WRP_MASK = 8'h01;

	// second option byte fields
	localparam int PLLF_BIT = 7;
	localparam int PLLBYP_BIT = 6;
	localparam int FPLLBYP_BIT = 5;
	localparam int RCOFF_BIT = 4;
	localparam int LVD_HI = 3;
	localparam int LVD_LO = 2;
	localparam int WDTYPE_BIT = 1;
	localparam int WDHALT_BIT = 0;

	// clock source field codes
	localparam logic [1:0] CLK_RESONATOR = 2'h0;
	localparam logic [1:0] CLK_EXT_PB4 = 2'h1;
	localparam logic [1:0] CLK_RESERVED = 2'h2;
	localparam logic [1:0] CLK_EXT_PC0 = 2'h3;

	// low-voltage detector field codes
	localparam logic [1:0] LVD_LOW = 2'h0;
	localparam logic [1:0] LVD_MEDIUM = 2'h1;
	localparam logic [1:0] LVD_HIGH = 2'h2;
	localparam logic [1:0] LVD_OFF = 2'h3;

	// sector 0 size for code 00, in bytes
	localparam logic [12:0] SECTOR_BASE_BYTES = 13'h0200;

	// command and watchdog register bits
	localparam int CMD_ERASE_BIT = 0;
	localparam int WDG_ACT_BIT = 0;

	// status register bits
	localparam int ST_PROG_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_WDG_BIT = 2;
	localparam int ST_FLASH_BIT = 3;

	localparam int SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEM_ERASE = 3'b010,
		ST_OPT_ERASE = 3'b100
	} erase_state_t;

endpackage : option_cfg_pkg

// >>> src/level_sync.sv
`timescale 1ns/1ps
`default_nettype none

module level_sync
	import option_cfg_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic async_i, // level from outside the clock domain
	output logic sync_o // synchronised level
);

	logic [SYNC_STAGES-1:0] stage_reg;
	logic [SYNC_STAGES-1:0] stage_next;

	always_comb
	begin
		stage_next = {stage_reg[SYNC_STAGES-2:0], async_i};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stage_reg <= '0;
		else
			stage_reg <= stage_next;
	end

	assign sync_o = stage_reg[SYNC_STAGES-1];

endmodule : level_sync

`default_nettype wire

// >>> tb/prog_tool.sv
`timescale 1ns/1ps
`default_nettype none

module prog_tool
	import option_cfg_pkg::*;
(
	input wire logic clk_i, // system clock
	input wire logic ack_i, // bus acknowledge
	input wire logic [31:0] dat_i, // bus read data
	output logic [7:0] adr_o, // bus address
	output logic [31:0] dat_o, // bus write data
	output logic we_o, // write enable
	output logic [3:0] sel_o, // byte lanes
	output logic cyc_o, // bus cycle
	output logic stb_o, // bus strobe
	output logic prog_o // programming mode pin
);
	// byte lanes of the next request; the bench may narrow them
	logic [3:0] lanes;

	initial
	begin
		{adr_o, dat_o, we_o, cyc_o, stb_o, prog_o} = '0;
		sel_o = 4'h0;
		lanes = 4'hF;
	end

	task automatic set_prog(input logic v);
		@(posedge clk_i);
		prog_o <= v;
	endtask : set_prog

	// one classic cycle; on release cyc, stb and we go low, the other lines go to the inverse of the last value
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, lanes, a, d};
		do
			@(posedge clk_i);
		while (ack_i !== 1'b1);
		q = dat_i;
		{cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <=
			{3'b000, ~lanes, ~a, ~d};
	endtask : bus

	// a bypassed PLL is only a legal setting with the x8 bit set
	task automatic put_opts(input logic [7:0] b0, input logic [7:0] b1);
		logic [31:0] q;
		logic [7:0] v;
		logic [7:0] u;
		v = b0;
		v[7] = 1'b1;
		if (!b1[RCOFF_BIT])
			v[5:4] = 2'b11;
		u = b1;
		if (u[PLLBYP_BIT])
			u[PLLF_BIT] = 1'b1;
		bus(1'b1, ADDR_OPT0, {24'h000000, v}, q);
		bus(1'b1, ADDR_OPT1, {24'h000000, u}, q);
	endtask : put_opts
endmodule : prog_tool
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			mismatches++; \
			$display("mismatch at %0t: got %0h want %0h", $time, got, exp); \
		end \
	end

module testbench
	import option_cfg_pkg::*;
;
	logic clk, rst, por, halt, done, we, cyc, stb, ack, prog;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic pkg20, rcen, sres, spb4, spc0, cres, rdp, wrp, fwa;
	logic px8, pen, fpen, lven, lvh, lvm, lvl, wdhw, wdact, hrst, merq;
	logic [12:0] secb;
	logic [1:0] i;
	logic [29:0] e;
	int mismatches, samples_checked, cycles;
	wire logic [29:0] dec = {pkg20, rcen, sres, spb4, spc0, cres, secb,
		rdp, wrp, fwa, px8, pen, fpen, lven, lvh, lvm, lvl, wdhw};

	prog_tool tool (.clk_i(clk), .ack_i(ack), .dat_i(rdat), .adr_o(adr),
		.dat_o(wdat), .we_o(we), .sel_o(sel), .cyc_o(cyc), .stb_o(stb),
		.prog_o(prog));

	option_byte_config_decoder u_dut (.clk_i(clk), .rst_i(rst), .por_i(por),
		.prog_mode_pin_i(prog), .halt_entry_i(halt),
		.mem_erase_done_i(done), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
		.we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
		.pkg_20pin_o(pkg20), .rc_osc_en_o(rcen), .sel_resonator_o(sres),
		.sel_ext_pb4_o(spb4), .sel_ext_pc0_o(spc0),
		.clock_field_reserved_o(cres), .sector_zero_bytes_o(secb),
		.readout_protect_o(rdp), .program_write_protect_o(wrp),
		.flash_write_allow_o(fwa), .pll_x8_o(px8), .pll_enable_o(pen),
		.fast_pll_enable_o(fpen), .lvd_enable_o(lven), .lvd_high_o(lvh),
		.lvd_medium_o(lvm), .lvd_low_o(lvl), .watchdog_hw_o(wdhw),
		.watchdog_active_o(wdact), .halt_reset_o(hrst),
		.mem_erase_req_o(merq));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	// decoded settings follow the store only while reset is held, except flash write allow, which drops as soon as the write protect bit is set
	task automatic do_reset(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task automatic halt_chk(input logic exp);
		@(posedge clk);
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		#1 `CHK(hrst, exp)
	endtask : halt_chk

	initial
	begin
		{rst, por, halt, done} = 4'b1100;
		{mismatches, samples_checked, cycles} = '0;
		repeat (20) @(posedge clk);
		{rst, por} <= 2'b00;
		repeat (4) @(posedge clk);
		`CHK(dec, {6'b110000, 13'h0400, 3'b001, 3'b100, 5'h00})
		tool.bus(1'b1, ADDR_OPT0, 32'h000000C0, q);
		tool.bus(1'b0, ADDR_OPT0, 32'h0, q);
		`CHK(q, 32'h0)
		tool.bus(1'b0, ADDR_OPT1, 32'h0, q);
		`CHK(q, 32'h0)
		tool.set_prog(1'b1);
		repeat (4) @(posedge clk);
		tool.bus(1'b0, ADDR_OPT0, 32'h0, q);
		`CHK(q, 32'h000000F4)
		tool.lanes = 4'hE;
		tool.bus(1'b1, ADDR_OPT1, 32'h00000000, q);
		tool.lanes = 4'hF;
		tool.bus(1'b0, ADDR_OPT1, 32'h0, q);
		`CHK(q, 32'h000000EF)
		tool.bus(1'b1, 8'h14, 32'h000000FF, q);
		tool.bus(1'b0, 8'h14, 32'h0, q);
		`CHK(q, 32'h0)
		for (int k = 0; k < 4; k++)
		begin
			i = k[1:0];
			tool.put_opts({1'b1, i[0], i, i, 2'b00},
				{i[0], i[1], ~i[0], 1'b1, i, 2'b11});
			do_reset(2);
			e = {i[0], 1'b0, i == 0, i == 1, i == 3, i == 2, 13'h0200 << i,
				3'b001, |i, ~i[1], i[0], i != 3, i == 2, i == 1, i == 0, 1'b0};
			`CHK(dec, e)
		end
		tool.put_opts(8'hF4, 8'hEF);
		repeat (2) @(posedge clk);
		`CHK(dec, e)
		tool.put_opts(8'hF4, 8'hED);
		do_reset(2);
		`CHK({wdhw, wdact}, 2'b11)
		halt_chk(1'b1);
		tool.put_opts(8'hF4, 8'hEC);
		do_reset(2);
		halt_chk(1'b0);
		tool.put_opts(8'hF4, 8'hEF);
		do_reset(2);
		`CHK({wdhw, wdact}, 2'b00)
		halt_chk(1'b0);
		tool.bus(1'b1, ADDR_WDG, 32'h1, q);
		repeat (2) @(posedge clk);
		`CHK(wdact, 1'b1)
		tool.bus(1'b0, ADDR_WDG, 32'h0, q);
		`CHK(q, 32'h00000001)
		halt_chk(1'b1);
		tool.put_opts(8'hF6, 8'hE3);
		do_reset(2);
		`CHK({rdp, fwa}, 2'b10)
		tool.bus(1'b1, ADDR_CMD, 32'h1, q);
		#1 `CHK(merq, 1'b1)
		tool.bus(1'b0, ADDR_STATUS, 32'h0, q);
		`CHK(q, 32'h00000003)
		repeat (3) @(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (3) @(posedge clk);
		tool.bus(1'b0, ADDR_OPT0, 32'h0, q);
		`CHK({merq, q}, {1'b0, 32'h000000F4})
		tool.bus(1'b1, ADDR_OPT0, 32'h000000F5, q);
		tool.bus(1'b1, ADDR_OPT0, 32'h000000F4, q);
		tool.bus(1'b0, ADDR_OPT0, 32'h0, q);
		`CHK(q, 32'h000000F5)
		tool.bus(1'b1, ADDR_CMD, 32'h1, q);
		repeat (4) @(posedge clk);
		tool.bus(1'b0, ADDR_OPT0, 32'h0, q);
		`CHK(q, 32'h000000F5)
		do_reset(2);
		`CHK({wrp, fwa}, 2'b10)
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
